// ==== common/sfap_map.vh ====
// register map, field positions, reset values and timing figures of the admission policy
`ifndef SFAP_MAP_VH
`define SFAP_MAP_VH

// register indices; the byte address on the bus is four times the index
`define SFAP_IDX_POLICY_CTRL    12'h331
`define SFAP_IDX_VLAN_STORM_HI  12'h332
`define SFAP_IDX_STORM_RATE_LO  12'h333

// reset values
`define SFAP_RST_POLICY_CTRL    8'hf0
`define SFAP_RST_VLAN_STORM_HI  8'h00
`define SFAP_RST_STORM_RATE_LO  8'h4a

// policy control fields
`define SFAP_B_MCAST_EXCL       6
`define SFAP_B_BP_CARRIER       5
`define SFAP_B_FAIR_MODE        4
`define SFAP_B_NO_EXC_DROP      3
`define SFAP_B_JUMBO_EN         2
`define SFAP_B_MAXCHK_DIS       1
`define SFAP_B_SHORT_PASS       0

// vlan and storm high fields
`define SFAP_B_NULL_VID_REP     3
`define SFAP_F_RATE_HI_MSB      2
`define SFAP_F_RATE_HI_LSB      0

// frame size limits in bytes
`define SFAP_LEN_JUMBO_MAX      14'h2328
`define SFAP_LEN_RELAXED_MAX    14'h07d0
`define SFAP_LEN_TAGGED_MAX     14'h05f2
`define SFAP_LEN_UNTAGGED_MAX   14'h05ee
`define SFAP_LEN_STD_MIN        14'h0040
`define SFAP_LEN_SHORT_MIN      14'h0020

// collisions at which a frame is given up
`define SFAP_EXC_COLL           5'h10

// storm budget granule: rate value shifted left by this many bits (times 64)
`define SFAP_STORM_GRAN_SH      6

// port speed codes
`define SFAP_SPD_10M            2'h0
`define SFAP_SPD_100M           2'h1

// storm periods in milliseconds, and clock rate in kHz
`define SFAP_PER_1G_MS          5
`define SFAP_PER_100M_MS        50
`define SFAP_PER_10M_MS         500
`define SFAP_CLK_KHZ            200000

`endif

// ==== core/sfap_policy.v ====
// switch-wide frame admission and mac policy with apb registers
//
// Behaviour
// RULE_01: multicast excluded from storm accounting when exclusion bit is one, else counted.
// RULE_02: back pressure bit: one carrier-sense based, zero collision based.
// RULE_03: fair mode on: non-flow-controlled port sharing an egress may be dropped.
// RULE_04: fair mode off: only flow-controlled port throttled, other port untouched.
// RULE_05: bit zero drops frames after 16 collisions; bit one keeps retrying.
// RULE_06: software setting no-drop bit should also enable alternate back-off mode.
// RULE_07: jumbo on admits frames within programmable limit, capped at 9000 bytes.
// RULE_08: jumbo on ignores the maximum-size check disable bit.
// RULE_09: jumbo off with check disabled accepts frames up to 2000 bytes.
// RULE_10: standard check: tagged up to 1522, untagged up to 1518, longer dropped.
// RULE_11: short pass set accepts frames between 32 and 64 bytes.
// RULE_12: short pass clear accepts only frames of at least 64 bytes.
// RULE_13: null vid replacement swaps zero vid for port default vid.
// RULE_14: 11-bit storm rate times 64 is the byte budget per port per period.
// RULE_15: storm period 5ms gigabit, 50ms 100 megabit, 500ms 10 megabit.
// RULE_16: reset storm rate gives about one percent of link bandwidth.
// RULE_17: low eight storm rate bits live in their own byte register, reset 0x4a.
// RULE_18: alternate back-off acts only on half-duplex ports.
// RULE_19: per-port byte counter cleared each period; frames dropped once budget spent.
// RULE_20: size verdict at frame end: jumbo, else 2000 or standard, plus short check.
`timescale 1ns/1ps
`include "sfap_map.vh"
module sfap_policy
#(
  parameter PER_1G_CYC   = `SFAP_PER_1G_MS * `SFAP_CLK_KHZ,
  parameter PER_100M_CYC = `SFAP_PER_100M_MS * `SFAP_CLK_KHZ,
  parameter PER_10M_CYC  = `SFAP_PER_10M_MS * `SFAP_CLK_KHZ
)
(
  clk_sys,
  rst_n,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  pstrb,
  prdata,
  pready,
  pslverr,
  port_speed,
  port_half_duplex,
  alt_backoff_en,
  rx_end,
  rx_port,
  rx_len,
  rx_tagged,
  rx_bcast,
  rx_mcast,
  rx_vid,
  rx_def_vid,
  jumbo_limit,
  vrd_valid,
  vrd_accept,
  vrd_size_drop,
  vrd_storm_drop,
  vrd_vid,
  col_end,
  col_count,
  col_drop,
  col_retry,
  fc_port_en,
  fc_congested,
  fc_pause,
  fc_drop,
  bp_carrier_mode,
  alt_backoff_act
);
  localparam NP = 6;

  input              clk_sys;
  input              rst_n;
  input              psel;
  input              penable;
  input              pwrite;
  input       [13:0] paddr;
  input       [31:0] pwdata;
  input       [3:0]  pstrb;
  output      [31:0] prdata;
  output             pready;
  output             pslverr;
  input       [11:0] port_speed;
  input       [5:0]  port_half_duplex;
  input              alt_backoff_en;
  input              rx_end;
  input       [2:0]  rx_port;
  input       [13:0] rx_len;
  input              rx_tagged;
  input              rx_bcast;
  input              rx_mcast;
  input       [11:0] rx_vid;
  input       [11:0] rx_def_vid;
  input       [13:0] jumbo_limit;
  output             vrd_valid;
  output             vrd_accept;
  output             vrd_size_drop;
  output             vrd_storm_drop;
  output      [11:0] vrd_vid;
  input              col_end;
  input       [4:0]  col_count;
  output             col_drop;
  output             col_retry;
  input       [5:0]  fc_port_en;
  input       [5:0]  fc_congested;
  output      [5:0]  fc_pause;
  output      [5:0]  fc_drop;
  output             bp_carrier_mode;
  output      [5:0]  alt_backoff_act;

  reg                rst_meta_r;
  reg                rst_sync_n;
  reg         [7:0]  policy_ctrl_r;
  reg         [7:0]  vlan_storm_hi_r;
  reg         [7:0]  storm_rate_lo_r;
  reg         [31:0] prdata_r;
  reg                pready_r;
  reg                pslverr_r;
  reg                vrd_valid_r;
  reg                vrd_accept_r;
  reg                vrd_size_drop_r;
  reg                vrd_storm_drop_r;
  reg         [11:0] vrd_vid_r;
  reg                col_drop_r;
  reg                col_retry_r;
  reg         [5:0]  fc_pause_r;
  reg         [5:0]  fc_drop_r;
  reg         [5:0]  alt_backoff_act_r;
  reg         [26:0] tmr_1g_r;
  reg         [26:0] tmr_100m_r;
  reg         [26:0] tmr_10m_r;
  reg         [13:0] len_max;
  reg         [13:0] len_min;
  reg         [31:0] rd_word;
  reg                rd_hit;

  wire        [11:0] reg_idx;
  wire               addr_aligned;
  wire               apb_access;
  wire               wr_en;
  wire        [13:0] jumbo_cap;
  wire        [10:0] storm_rate;
  wire        [16:0] storm_budget;
  wire               frame_counted;
  wire               size_ok;
  wire        [5:0]  storm_over;
  wire               tick_1g;
  wire               tick_100m;
  wire               tick_10m;

  // reset release through two flops; only the second is used anywhere
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // word-indexed decode; one wait state gives a registered answer
  assign reg_idx      = paddr[13:2];
  assign addr_aligned = (paddr[1:0] == 2'h0);
  assign apb_access   = psel & penable & ~pready_r;
  // writes land on the edge that samples pready high, never earlier
  assign wr_en        = psel & penable & pready_r & pwrite & rd_hit & pstrb[0];

  // read mux and hit detection
  always @*
  begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b0;
    if (addr_aligned && reg_idx == `SFAP_IDX_POLICY_CTRL)
    begin
      rd_word = {24'h000000, policy_ctrl_r};
      rd_hit  = 1'b1;
    end
    else if (addr_aligned && reg_idx == `SFAP_IDX_VLAN_STORM_HI)
    begin
      rd_word = {24'h000000, vlan_storm_hi_r};
      rd_hit  = 1'b1;
    end
    else if (addr_aligned && reg_idx == `SFAP_IDX_STORM_RATE_LO)
    begin
      rd_word = {24'h000000, storm_rate_lo_r}; // [RULE_17]
      rd_hit  = 1'b1;
    end
  end

  // apb answer and register writes; unmapped addresses answer with pslverr
  always @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pready_r        <= 1'b0;
      pslverr_r       <= 1'b0;
      prdata_r        <= 32'h00000000;
      policy_ctrl_r   <= `SFAP_RST_POLICY_CTRL;
      vlan_storm_hi_r <= `SFAP_RST_VLAN_STORM_HI;
      storm_rate_lo_r <= `SFAP_RST_STORM_RATE_LO; // [RULE_16] [RULE_17]
    end
    else
    begin
      pready_r  <= apb_access;
      pslverr_r <= apb_access & ~rd_hit;
      prdata_r  <= (apb_access && !pwrite) ? rd_word : 32'h00000000;
      if (wr_en && reg_idx == `SFAP_IDX_POLICY_CTRL)
        policy_ctrl_r <= pwdata[7:0];
      if (wr_en && reg_idx == `SFAP_IDX_VLAN_STORM_HI)
        vlan_storm_hi_r <= pwdata[7:0];
      if (wr_en && reg_idx == `SFAP_IDX_STORM_RATE_LO)
        storm_rate_lo_r <= pwdata[7:0];
    end
  end

  // storm period timebases, one per speed class
  assign tick_1g   = ({5'h00, tmr_1g_r} == PER_1G_CYC - 1);     // [RULE_15]
  assign tick_100m = ({5'h00, tmr_100m_r} == PER_100M_CYC - 1); // [RULE_15]
  assign tick_10m  = ({5'h00, tmr_10m_r} == PER_10M_CYC - 1);   // [RULE_15]

  always @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tmr_1g_r   <= 27'h0000000;
      tmr_100m_r <= 27'h0000000;
      tmr_10m_r  <= 27'h0000000;
    end
    else
    begin
      tmr_1g_r   <= tick_1g ? 27'h0000000 : tmr_1g_r + 27'h0000001;
      tmr_100m_r <= tick_100m ? 27'h0000000 : tmr_100m_r + 27'h0000001;
      tmr_10m_r  <= tick_10m ? 27'h0000000 : tmr_10m_r + 27'h0000001;
    end
  end

  // full storm rate and byte budget
  assign storm_rate   = {vlan_storm_hi_r[`SFAP_F_RATE_HI_MSB:`SFAP_F_RATE_HI_LSB],
                         storm_rate_lo_r};                                  // [RULE_17]
  assign storm_budget = {storm_rate, 6'h00};                                // [RULE_14]
  assign frame_counted = rx_bcast | (rx_mcast & ~policy_ctrl_r[`SFAP_B_MCAST_EXCL]); // [RULE_01]

  // one meter per input port, each on the period of its own speed
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi = gi + 1)
    begin : g_meter
      wire [1:0] spd;
      wire       ptick;
      assign spd   = port_speed[2*gi+1:2*gi];
      assign ptick = (spd == `SFAP_SPD_10M)  ? tick_10m :
                     (spd == `SFAP_SPD_100M) ? tick_100m : tick_1g; // [RULE_15]
      sfap_storm_meter u_meter
      (
        .clk_sys       (clk_sys),
        .rst_sync_n    (rst_sync_n),
        .period_tick   (ptick),
        .frame_end     (rx_end & (rx_port == gi)),
        .frame_counted (frame_counted),
        .frame_charge  (size_ok),
        .frame_len     (rx_len),
        .budget        (storm_budget),
        .over          (storm_over[gi])
      );
    end
  endgenerate

  // size window; the jumbo limit is clipped to the hard ceiling
  assign jumbo_cap = (jumbo_limit > `SFAP_LEN_JUMBO_MAX) ? `SFAP_LEN_JUMBO_MAX
                                                         : jumbo_limit; // [RULE_07]
  always @*
  begin
    if (policy_ctrl_r[`SFAP_B_JUMBO_EN])
      len_max = jumbo_cap;                   // [RULE_07] [RULE_08] [RULE_20]
    else if (policy_ctrl_r[`SFAP_B_MAXCHK_DIS])
      len_max = `SFAP_LEN_RELAXED_MAX;       // [RULE_09]
    else if (rx_tagged)
      len_max = `SFAP_LEN_TAGGED_MAX;        // [RULE_10]
    else
      len_max = `SFAP_LEN_UNTAGGED_MAX;      // [RULE_10]
    len_min = policy_ctrl_r[`SFAP_B_SHORT_PASS] ? `SFAP_LEN_SHORT_MIN  // [RULE_11]
                                                : `SFAP_LEN_STD_MIN;   // [RULE_12]
  end
  assign size_ok = (rx_len >= len_min) && (rx_len <= len_max); // [RULE_20]

  // per-frame verdict one cycle after frame end
  always @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      vrd_valid_r      <= 1'b0;
      vrd_accept_r     <= 1'b0;
      vrd_size_drop_r  <= 1'b0;
      vrd_storm_drop_r <= 1'b0;
      vrd_vid_r        <= 12'h000;
    end
    else
    begin
      vrd_valid_r      <= rx_end;
      vrd_size_drop_r  <= rx_end & ~size_ok;                                   // [RULE_20]
      vrd_storm_drop_r <= rx_end & size_ok & frame_counted & storm_over[rx_port]; // [RULE_19]
      vrd_accept_r     <= rx_end & size_ok & ~(frame_counted & storm_over[rx_port]);
      if (rx_end)
        vrd_vid_r <= (vlan_storm_hi_r[`SFAP_B_NULL_VID_REP] && rx_tagged &&
                      rx_vid == 12'h000) ? rx_def_vid : rx_vid;                // [RULE_13]
    end
  end

  // collision outcome, flow control and back-off qualification
  always @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      col_drop_r        <= 1'b0;
      col_retry_r       <= 1'b0;
      fc_pause_r        <= 6'h00;
      fc_drop_r         <= 6'h00;
      alt_backoff_act_r <= 6'h00;
    end
    else
    begin
      col_drop_r  <= col_end & (col_count >= `SFAP_EXC_COLL) &
                     ~policy_ctrl_r[`SFAP_B_NO_EXC_DROP];                     // [RULE_05]
      col_retry_r <= col_end & ((col_count < `SFAP_EXC_COLL) |
                     policy_ctrl_r[`SFAP_B_NO_EXC_DROP]);                     // [RULE_05]
      fc_pause_r  <= fc_congested & fc_port_en;                               // [RULE_04]
      // drops of non-flow-controlled ports only when a flow-controlled one shares the egress
      fc_drop_r   <= (policy_ctrl_r[`SFAP_B_FAIR_MODE] && |(fc_congested & fc_port_en)) ?
                     (fc_congested & ~fc_port_en) : 6'h00;                    // [RULE_03] [RULE_04]
      // bit comes from the neighbouring register; software keeps it paired with no-drop
      alt_backoff_act_r <= {NP{alt_backoff_en}} & port_half_duplex;           // [RULE_18] [RULE_06]
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign vrd_valid       = vrd_valid_r;
  assign vrd_accept      = vrd_accept_r;
  assign vrd_size_drop   = vrd_size_drop_r;
  assign vrd_storm_drop  = vrd_storm_drop_r;
  assign vrd_vid         = vrd_vid_r;
  assign col_drop        = col_drop_r;
  assign col_retry       = col_retry_r;
  assign fc_pause        = fc_pause_r;
  assign fc_drop         = fc_drop_r;
  assign bp_carrier_mode = policy_ctrl_r[`SFAP_B_BP_CARRIER]; // [RULE_02]
  assign alt_backoff_act = alt_backoff_act_r;
endmodule

// ==== core/sfap_storm_meter.v ====
// per-input-port broadcast storm byte meter
`timescale 1ns/1ps
module sfap_storm_meter
(
  clk_sys,
  rst_sync_n,
  period_tick,
  frame_end,
  frame_counted,
  frame_charge,
  frame_len,
  budget,
  over
);
  input         clk_sys;
  input         rst_sync_n;
  input         period_tick;
  input         frame_end;
  input         frame_counted;
  input         frame_charge;
  input  [13:0] frame_len;
  input  [16:0] budget;
  output        over;

  reg    [17:0] bytes_r;
  reg    [17:0] bytes_nxt;
  wire   [18:0] sum;

  // budget exhausted once the spent bytes reach it
  assign over = (bytes_r >= {1'b0, budget}); // [RULE_19]
  assign sum  = {1'b0, bytes_r} + {5'h00, frame_len};

  // the period boundary wins over a charge in the same cycle, so a new period starts clean
  always @*
  begin
    bytes_nxt = bytes_r;
    if (period_tick)
      bytes_nxt = 18'h00000; // [RULE_19]
    else if (frame_end && frame_counted && frame_charge && !over)
      bytes_nxt = sum[18] ? 18'h3ffff : sum[17:0]; // saturate, never wrap to a small count
  end

  always @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      bytes_r <= 18'h00000;
    else
      bytes_r <= bytes_nxt;
  end
endmodule

// ==== testbench/sfap_policy_monitor.sv ====
// concurrent checks on the admission policy ports
`timescale 1ns/1ps
module sfap_policy_chk
(
  input wire        clk_sys,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        rx_end,
  input wire [13:0] rx_len,
  input wire        vrd_valid,
  input wire        vrd_accept,
  input wire        vrd_size_drop,
  input wire        vrd_storm_drop,
  input wire        col_end,
  input wire [4:0]  col_count,
  input wire        col_drop,
  input wire        col_retry,
  input wire [5:0]  fc_port_en,
  input wire [5:0]  fc_congested,
  input wire [5:0]  fc_pause,
  input wire [5:0]  fc_drop,
  input wire [5:0]  port_half_duplex,
  input wire        alt_backoff_en,
  input wire [5:0]  alt_backoff_act
);
  reg [1:0] up_r;
  // the design's own reset lags rst_n by two edges, so checks wait three
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      up_r <= 2'h0;
    else if (up_r != 2'h3)
      up_r <= up_r + 2'h1;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (up_r != 2'h3);
  // apb phases
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && !pready; endsequence
  property p_apb_wait; s_setup ##1 s_access |=> pready; endproperty
  property p_apb_quiet; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  property p_vrd_lat; rx_end |=> vrd_valid; endproperty
  property p_vrd_one;
    vrd_valid |-> $onehot({vrd_accept, vrd_size_drop, vrd_storm_drop});
  endproperty
  property p_short; rx_end && rx_len < 14'h20 |=> vrd_size_drop; endproperty
  property p_giant; rx_end && rx_len > 14'h2328 |=> vrd_size_drop; endproperty
  property p_col_few; col_end && col_count < 5'h10 |=> col_retry && !col_drop; endproperty
  property p_col_one; col_end |=> col_drop != col_retry; endproperty
  property p_fc_pause; 1'b1 |=> fc_pause == $past(fc_congested & fc_port_en); endproperty
  property p_fc_drop;
    1'b1 |=> (fc_drop & $past(fc_port_en)) == 6'h0
      && (fc_drop == 6'h0 || |$past(fc_congested & fc_port_en));
  endproperty
  property p_alt;
    1'b1 |=> alt_backoff_act == ($past(port_half_duplex) & {6{$past(alt_backoff_en)}});
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready late");
  a_apb_quiet: assert property (p_apb_quiet) else $error("apb answer outside pready");
  a_vrd_lat: assert property (p_vrd_lat) else $error("verdict late");
  a_vrd_one: assert property (p_vrd_one) else $error("verdict not one-hot");
  a_short: assert property (p_short) else $error("runt frame kept");
  a_giant: assert property (p_giant) else $error("giant frame kept");
  a_col_few: assert property (p_col_few) else $error("early collision drop");
  a_col_one: assert property (p_col_one) else $error("collision verdict");
  a_fc_pause: assert property (p_fc_pause) else $error("pause mismatch");
  a_fc_drop: assert property (p_fc_drop) else $error("fair drop mismatch");
  a_alt: assert property (p_alt) else $error("back-off mismatch");
endmodule
bind sfap_policy sfap_policy_chk i_sfap_policy_chk
(
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_end(rx_end), .rx_len(rx_len),
  .vrd_valid(vrd_valid), .vrd_accept(vrd_accept), .vrd_size_drop(vrd_size_drop),
  .vrd_storm_drop(vrd_storm_drop), .col_end(col_end), .col_count(col_count),
  .col_drop(col_drop), .col_retry(col_retry), .fc_port_en(fc_port_en),
  .fc_congested(fc_congested), .fc_pause(fc_pause), .fc_drop(fc_drop),
  .port_half_duplex(port_half_duplex), .alt_backoff_en(alt_backoff_en),
  .alt_backoff_act(alt_backoff_act)
);

// ==== testbench/sfap_policy_test.sv ====
// self-checking bench for the admission policy
`timescale 1ns/1ps
`include "sfap_map.vh"
module sfap_policy_test;
  reg         clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [13:0] paddr = 14'h0, rx_len = 14'h0, jumbo_limit = 14'h0;
  reg  [31:0] pwdata = 32'h0, rd;
  reg  [3:0]  pstrb = 4'hf;
  reg  [11:0] port_speed = 12'h0, rx_vid = 12'h0, rx_def_vid = 12'h123;
  reg  [5:0]  port_half_duplex = 6'h0, fc_port_en = 6'h0, fc_congested = 6'h0;
  reg         alt_backoff_en = 1'b0, rx_end = 1'b0, rx_tagged = 1'b0, rx_bcast = 1'b0;
  reg         rx_mcast = 1'b0, col_end = 1'b0, rerr;
  reg  [2:0]  rx_port = 3'h0;
  reg  [4:0]  col_count = 5'h0;
  wire [31:0] prdata;
  wire        pready, pslverr, vrd_valid, vrd_accept, vrd_size_drop, vrd_storm_drop;
  wire        col_drop, col_retry, bp_carrier_mode;
  wire [11:0] vrd_vid;
  wire [5:0]  fc_pause, fc_drop, alt_backoff_act;
  integer     err_total = 0, n_compared = 0, t0, t1;
  // short storm periods keep the run small: 2000, 4000 and 8000 cycles
  sfap_policy #(.PER_1G_CYC(2000), .PER_100M_CYC(4000), .PER_10M_CYC(8000)) i_sfap_policy
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_speed(port_speed), .port_half_duplex(port_half_duplex),
    .alt_backoff_en(alt_backoff_en), .rx_end(rx_end), .rx_port(rx_port), .rx_len(rx_len),
    .rx_tagged(rx_tagged), .rx_bcast(rx_bcast), .rx_mcast(rx_mcast), .rx_vid(rx_vid),
    .rx_def_vid(rx_def_vid), .jumbo_limit(jumbo_limit), .vrd_valid(vrd_valid),
    .vrd_accept(vrd_accept), .vrd_size_drop(vrd_size_drop), .vrd_storm_drop(vrd_storm_drop),
    .vrd_vid(vrd_vid), .col_end(col_end), .col_count(col_count), .col_drop(col_drop),
    .col_retry(col_retry), .fc_port_en(fc_port_en), .fc_congested(fc_congested),
    .fc_pause(fc_pause), .fc_drop(fc_drop), .bp_carrier_mode(bp_carrier_mode),
    .alt_backoff_act(alt_backoff_act)
  );
  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;
  task end_sim;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // one apb transfer; read data and error are taken at the pready edge
  task apb(input wr, input [11:0] idx, input [1:0] lo, input [3:0] st, input [31:0] wd);
    integer n;
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, lo};
      pstrb <= st;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 20)
      begin
        @(posedge clk_sys);
        n = n + 1;
      end
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20)
      begin
        err_total = err_total + 1;
        end_sim;
      end
    end
  endtask
  task wr(input [11:0] idx, input [7:0] d);
    apb(1'b1, idx, 2'h0, 4'hf, {24'h0, d});
  endtask
  task rdchk(input [11:0] idx, input [7:0] exp);
    begin
      apb(1'b0, idx, 2'h0, 4'hf, 32'h0);
      chk("register", {24'h0, exp}, rd);
    end
  endtask
  // one frame end pulse; returns on the edge that closes the verdict cycle
  task frame(input [2:0] p, input [13:0] len, input tg, bc, mc, input [11:0] vid);
    begin
      @(posedge clk_sys);
      rx_end <= 1'b1;
      rx_port <= p;
      rx_len <= len;
      rx_tagged <= tg;
      rx_bcast <= bc;
      rx_mcast <= mc;
      rx_vid <= vid;
      @(posedge clk_sys);
      rx_end <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task t_regs;
    begin
      rdchk(`SFAP_IDX_POLICY_CTRL, 8'hf0);
      rdchk(`SFAP_IDX_VLAN_STORM_HI, 8'h00);
      rdchk(`SFAP_IDX_STORM_RATE_LO, 8'h4a);
      chk("carrier mode", 1, bp_carrier_mode);
      apb(1'b1, `SFAP_IDX_POLICY_CTRL, 2'h0, 4'hf, 32'hffffffd0);
      rdchk(`SFAP_IDX_POLICY_CTRL, 8'hd0);
      chk("carrier mode", 0, bp_carrier_mode);
      apb(1'b1, `SFAP_IDX_POLICY_CTRL, 2'h0, 4'h0, 32'hf0);
      rdchk(`SFAP_IDX_POLICY_CTRL, 8'hd0);
      wr(`SFAP_IDX_VLAN_STORM_HI, 8'h50);
      rdchk(`SFAP_IDX_VLAN_STORM_HI, 8'h50);
      apb(1'b0, 12'h334, 2'h0, 4'hf, 32'h0);
      chk("unmapped err", 1, rerr);
      chk("unmapped data", 0, rd);
      apb(1'b1, `SFAP_IDX_STORM_RATE_LO, 2'h1, 4'hf, 32'h11);
      chk("misaligned err", 1, rerr);
      rdchk(`SFAP_IDX_STORM_RATE_LO, 8'h4a);
      $display("registers done");
    end
  endtask
  task size_case(input [7:0] ctrl, input [13:0] len, input tg, input [13:0] jl, input ok);
    begin
      wr(`SFAP_IDX_POLICY_CTRL, ctrl);
      jumbo_limit <= jl;
      frame(3'h2, len, tg, 1'b0, 1'b0, 12'h0);
      chk("accept", ok, vrd_accept);
      chk("size drop", !ok, vrd_size_drop);
    end
  endtask
  task t_size;
    begin
      size_case(8'hf0, 14'd63, 0, 14'd0, 0);
      size_case(8'hf0, 14'd64, 0, 14'd0, 1);
      size_case(8'hf0, 14'd1518, 0, 14'd0, 1);
      size_case(8'hf0, 14'd1519, 0, 14'd0, 0);
      size_case(8'hf0, 14'd1522, 1, 14'd0, 1);
      size_case(8'hf0, 14'd1523, 1, 14'd0, 0);
      size_case(8'hf1, 14'd32, 0, 14'd0, 1);
      size_case(8'hf1, 14'd31, 0, 14'd0, 0);
      size_case(8'hf2, 14'd2000, 1, 14'd0, 1);
      size_case(8'hf2, 14'd2001, 0, 14'd0, 0);
      size_case(8'hf6, 14'd3000, 0, 14'd3000, 1);
      size_case(8'hf6, 14'd3001, 0, 14'd3000, 0);
      size_case(8'hf4, 14'd9000, 0, 14'd9500, 1);
      size_case(8'hf4, 14'd9001, 0, 14'd9500, 0);
      $display("size done");
    end
  endtask
  task col_case(input [7:0] ctrl, input [4:0] cnt, input drop);
    begin
      wr(`SFAP_IDX_POLICY_CTRL, ctrl);
      col_end <= 1'b1;
      col_count <= cnt;
      @(posedge clk_sys);
      col_end <= 1'b0;
      @(posedge clk_sys);
      chk("coll drop", drop, col_drop);
      chk("coll retry", !drop, col_retry);
    end
  endtask
  task t_misc;
    begin
      col_case(8'hf0, 5'd15, 0);
      col_case(8'hf0, 5'd16, 1);
      col_case(8'hf8, 5'd16, 0);
      col_case(8'hf8, 5'd31, 0);
      chk("backoff", 0, alt_backoff_act);
      alt_backoff_en <= 1'b1;
      port_half_duplex <= 6'h2a;
      fc_port_en <= 6'h01;
      fc_congested <= 6'h03;
      repeat (2) @(posedge clk_sys);
      chk("backoff", 6'h2a, alt_backoff_act);
      chk("pause", 6'h01, fc_pause);
      chk("fair drop", 6'h02, fc_drop);
      wr(`SFAP_IDX_POLICY_CTRL, 8'he0);
      repeat (2) @(posedge clk_sys);
      chk("pause", 6'h01, fc_pause);
      chk("fair drop", 6'h00, fc_drop);
      wr(`SFAP_IDX_VLAN_STORM_HI, 8'h08);
      frame(3'h3, 14'd100, 1, 0, 0, 12'h000);
      chk("vid", 12'h123, vrd_vid);
      frame(3'h3, 14'd100, 1, 0, 0, 12'h005);
      chk("vid", 12'h005, vrd_vid);
      wr(`SFAP_IDX_VLAN_STORM_HI, 8'h00);
      frame(3'h3, 14'd100, 1, 0, 0, 12'h000);
      chk("vid", 12'h000, vrd_vid);
      $display("collision, flow control and vid done");
    end
  endtask
  // send broadcasts until a drop is followed by an accept: a period boundary
  task sync(input [2:0] p, output integer t);
    integer n;
    reg     seen;
    begin
      n = 0;
      seen = 1'b0;
      while (!(seen && vrd_accept) && n < 6000)
      begin
        seen = vrd_storm_drop;
        frame(p, 14'd100, 0, 1, 0, 12'h0);
        n = n + 1;
      end
      t = $time;
      if (n == 6000)
      begin
        err_total = err_total + 1;
        end_sim;
      end
    end
  endtask
  task per(input [2:0] p, input integer ns);
    begin
      sync(p, t0);
      sync(p, t1);
      chk("period", 1, (t1 - t0 >= ns - 15) && (t1 - t0 <= ns + 15));
    end
  endtask
  task t_storm;
    begin
      port_speed <= 12'h006;
      wr(`SFAP_IDX_STORM_RATE_LO, 8'h01);
      wr(`SFAP_IDX_POLICY_CTRL, 8'hf0);
      sync(3'h0, t0);
      frame(3'h0, 14'd100, 0, 1, 0, 12'h0);
      chk("storm drop", 1, vrd_storm_drop);
      frame(3'h0, 14'd100, 0, 0, 1, 12'h0);
      chk("mcast pass", 1, vrd_accept);
      wr(`SFAP_IDX_POLICY_CTRL, 8'hb0);
      frame(3'h0, 14'd100, 0, 0, 1, 12'h0);
      chk("mcast drop", 1, vrd_storm_drop);
      sync(3'h0, t1);
      chk("period", 1, (t1 - t0 >= 9985) && (t1 - t0 <= 10015));
      wr(`SFAP_IDX_STORM_RATE_LO, 8'h02);
      sync(3'h1, t0);
      frame(3'h1, 14'd100, 0, 1, 0, 12'h0);
      chk("budget pass", 1, vrd_accept);
      frame(3'h1, 14'd100, 0, 1, 0, 12'h0);
      chk("budget drop", 1, vrd_storm_drop);
      per(3'h1, 20000);
      per(3'h2, 40000);
      $display("storm done");
    end
  endtask
  // reset, the tests, then a second reset after the last test
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs;
    t_size;
    t_misc;
    t_storm;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdchk(`SFAP_IDX_POLICY_CTRL, 8'hf0);
    $display("second reset done");
    end_sim;
  end
endmodule
